// ### lsetc_pkg.sv
// shared constants for the line scan exposure trigger control block
package lsetc_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned TICKS_PER_US = CLK_HZ / 1000000;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] EXPO_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] TEMP_OFS = 8'h14;
  // control field positions
  localparam int CTRL_TRIG_BIT = 0;
  localparam int CTRL_WIDTH_BIT = 1;
  localparam int CTRL_RESET_BIT = 2;
  // status field positions
  localparam int ST_LINE_BIT = 0;
  localparam int ST_READ_BIT = 1;
  localparam int ST_HOT_BIT = 2;
  localparam int ST_WIDTH = 3;
  // line period and exposure in microseconds, temperature limit in degrees C; defaults and limits
  localparam logic [19:0] PERIOD_US_RST = 20'h00064;
  localparam logic [19:0] PERIOD_US_MIN = 20'h00015;
  localparam logic [19:0] PERIOD_US_MAX = 20'hf4240;
  localparam logic [11:0] EXPO_US_RST = 12'h032;
  localparam logic [11:0] EXPO_US_MIN = 12'h004;
  localparam logic [11:0] EXPO_US_MAX = 12'hbb8;
  localparam logic [7:0] TEMP_LIMIT_C = 8'h4b;
endpackage

// ### lsetc_top.sv
// line trigger and exposure timing control with wishbone registers
`timescale 1ns/1ns
`default_nettype none
module lsetc_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_line_sync,
  input wire logic [7:0] tempC,
  output logic exposing,
  output logic lineBegin,
  output logic readoutStart,
  output logic errorLed,
  output logic irq
);
  // status and mask width, taken from the package once
  localparam int ST_WIDTH_L = lsetc_pkg::ST_WIDTH;

  // all state in one struct; the comb process edits a copy, the flop
  // process registers it, so every output below comes from a flop
  typedef struct packed {
    logic [2:0] syncPipe; // sync synchroniser
    logic syncLvl; // agreed sync level
    logic trigEn;
    logic widthMode;
    logic [19:0] periodUs;
    logic [11:0] expoUs;
    logic [7:0] tempLast;
    logic [7:0] usDiv; // microsecond enable divider
    logic [19:0] lineCnt; // line timer, us
    logic [11:0] expoCnt; // exposure timer, us
    logic expo;
    logic lineP;
    logic readP;
    logic hot;
    logic [ST_WIDTH_L-1:0] status;
    logic [ST_WIDTH_L-1:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic irqO;
  } lsetc_state_type;

  lsetc_state_type s_reg, s_next;

  // clamp exposure into range and below the line period
  // used at write time and again at use, since a later period write
  // may shrink the line below a stored exposure
  function automatic logic [11:0] clampExpo(input logic [11:0] v,
                                            input logic [19:0] per);
    logic [11:0] r;
    r = v;
    if (r < lsetc_pkg::EXPO_US_MIN) begin
      r = lsetc_pkg::EXPO_US_MIN;
    end
    if (r > lsetc_pkg::EXPO_US_MAX) begin
      r = lsetc_pkg::EXPO_US_MAX;
    end
    if ({8'h00, r} >= per) begin
      r = 12'(per - 20'h00001); // line period dominates
    end
    return r;
  endfunction

  logic usTick;
  logic syncRise;
  logic syncFall;
  logic wbReq;
  logic [3:0] evt;

  // register process
  // synchronous reset loads the power-up settings: free run, 100 us
  // line period and 50 us exposure; everything else clears
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.periodUs <= lsetc_pkg::PERIOD_US_RST;
      s_reg.expoUs <= lsetc_pkg::EXPO_US_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.lineP = 1'b0;
    s_next.readP = 1'b0;
    s_next.ack = 1'b0;
    evt = '0;
    // three stage sync; second and third must agree
    // the pin is asynchronous to sys_clk, so stage one is never read
    // by logic; a one-cycle glitch cannot reach the filtered level
    s_next.syncPipe = {s_reg.syncPipe[1:0], external_line_sync};
    if (s_reg.syncPipe[2] == s_reg.syncPipe[1]) begin
      s_next.syncLvl = s_reg.syncPipe[2];
    end
    syncRise = s_next.syncLvl & ~s_reg.syncLvl;
    syncFall = ~s_next.syncLvl & s_reg.syncLvl;
    // microsecond enable
    usTick = (s_reg.usDiv == 8'(lsetc_pkg::TICKS_PER_US - 1));
    s_next.usDiv = usTick ? 8'h00 : s_reg.usDiv + 8'h01;
    s_next.tempLast = tempC;
    // over-temperature latches until reset command
    if (s_reg.tempLast > lsetc_pkg::TEMP_LIMIT_C) begin
      s_next.hot = 1'b1;
    end
    if (s_reg.hot) begin
      s_next.expo = 1'b0;
    end else if (!s_reg.trigEn) begin
      // free run: line timer reloads on expiry
      // the divider keeps running, so a line is exactly period ticks
      if (usTick) begin
        if (s_reg.lineCnt + 20'h00001 >= s_reg.periodUs) begin
          s_next.lineCnt = '0;
          s_next.lineP = 1'b1;
          s_next.expo = 1'b1;
          s_next.expoCnt = '0;
        end else begin
          s_next.lineCnt = s_reg.lineCnt + 20'h00001;
        end
      end
    end else if (s_reg.widthMode) begin
      // pulse-width: timers unused
      // exposure follows the filtered level, three or four cycles late
      if (syncRise) begin
        s_next.expo = 1'b1;
        s_next.lineP = 1'b1;
      end else if (syncFall) begin
        s_next.expo = 1'b0;
        s_next.readP = 1'b1;
      end
    end else if (syncFall) begin
      // timed external: line timer ignored
      s_next.expo = 1'b1;
      s_next.expoCnt = '0;
      s_next.lineP = 1'b1;
      // restart the microsecond divider so the exposure is whole ticks
      // long; free run needs no restart as it starts on a tick
      s_next.usDiv = 8'h00;
    end
    // timed exposure end; skipped in pulse-width mode and on the cycle
    // that a new external start restarts the exposure counter
    if (!s_reg.hot && s_reg.expo && usTick
        && !(s_reg.trigEn && (s_reg.widthMode || syncFall))) begin
      if (s_reg.expoCnt + 12'h001
          >= clampExpo(s_reg.expoUs, s_reg.periodUs)) begin
        s_next.expo = 1'b0;
        s_next.readP = 1'b1;
      end else begin
        s_next.expoCnt = s_reg.expoCnt + 12'h001;
      end
    end
    // bus slave, one wait: ack one cycle after request
    // the ack term in the request blocks a second take while ack stands,
    // so a master that drops cyc and stb when it samples ack gets exactly one transfer; held on, it gets one every second cycle
    wbReq = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    s_next.ack = wbReq;
    if (wbReq && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        lsetc_pkg::CTRL_OFS: begin
          s_next.trigEn = wb_dat_i[lsetc_pkg::CTRL_TRIG_BIT];
          // pulse width only with trigger on
          s_next.widthMode = wb_dat_i[lsetc_pkg::CTRL_WIDTH_BIT]
                             & wb_dat_i[lsetc_pkg::CTRL_TRIG_BIT];
          if (wb_dat_i[lsetc_pkg::CTRL_RESET_BIT]) begin
            s_next.hot = 1'b0;
          end
        end
        lsetc_pkg::PERIOD_OFS: begin
          // honoured only in free run
          if (!s_reg.trigEn) begin
            s_next.periodUs = wb_dat_i[19:0] < lsetc_pkg::PERIOD_US_MIN ?
              lsetc_pkg::PERIOD_US_MIN :
              (wb_dat_i[19:0] > lsetc_pkg::PERIOD_US_MAX ?
               lsetc_pkg::PERIOD_US_MAX : wb_dat_i[19:0]);
            s_next.lineCnt = '0;
          end
        end
        lsetc_pkg::EXPO_OFS: begin
          s_next.expoUs = clampExpo(wb_dat_i[11:0], s_reg.periodUs);
        end
        lsetc_pkg::STATUS_OFS: begin
          s_next.status = s_reg.status & ~wb_dat_i[ST_WIDTH_L-1:0];
        end
        lsetc_pkg::MASK_OFS: begin
          s_next.mask = wb_dat_i[ST_WIDTH_L-1:0];
        end
        default: begin
        end
      endcase
    end
    // events set sticky bits, set wins over clear
    evt[lsetc_pkg::ST_LINE_BIT] = s_next.lineP;
    evt[lsetc_pkg::ST_READ_BIT] = s_next.readP;
    evt[lsetc_pkg::ST_HOT_BIT] = s_next.hot & ~s_reg.hot;
    s_next.status = s_next.status | evt[ST_WIDTH_L-1:0];
    s_next.irqO = |(s_next.status & s_next.mask);
    // read mux
    // read data is registered with ack, so it stands exactly in the
    // cycle that ack does; unmapped places read zero
    s_next.rdata = '0;
    if (wbReq && !wb_we_i) begin
      unique case (wb_adr_i)
        lsetc_pkg::CTRL_OFS: begin
          s_next.rdata = {29'h0, s_reg.hot, s_reg.widthMode, s_reg.trigEn};
        end
        lsetc_pkg::PERIOD_OFS: s_next.rdata = {12'h000, s_reg.periodUs};
        lsetc_pkg::EXPO_OFS: s_next.rdata = {20'h00000, s_reg.expoUs};
        lsetc_pkg::STATUS_OFS: begin
          s_next.rdata = {29'h0, s_reg.status};
        end
        lsetc_pkg::MASK_OFS: s_next.rdata = {29'h0, s_reg.mask};
        lsetc_pkg::TEMP_OFS: s_next.rdata = {24'h000000, s_reg.tempLast};
        default: s_next.rdata = '0;
      endcase
    end
  end

  // outputs straight from flops
  // no gate sits between a flop and a pin, so downstream logic sees
  // clean edges one cycle after the decision
  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign exposing = s_reg.expo;
  assign lineBegin = s_reg.lineP;
  assign readoutStart = s_reg.readP;
  assign errorLed = s_reg.hot;
  assign irq = s_reg.irqO;

  // pulse-width exposure tracks the filtered sync
  AST_WIDTH_TRACK: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.trigEn && s_reg.widthMode && !s_reg.hot && $rose(s_reg.syncLvl)
    |-> exposing) else $error("exposure not started on sync rise");
  AST_WIDTH_END: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.trigEn && s_reg.widthMode && $fell(s_reg.syncLvl) && !s_reg.hot
    |-> !exposing && readoutStart) else $error("no readout on fall");
  AST_HOT_STOP: assert property (@(posedge sys_clk) disable iff (!resetn)
    errorLed |=> !exposing) else $error("imaging while hot");
  AST_NO_WIDTH_FREE: assert property (@(posedge sys_clk) disable iff (!resetn)
    !s_reg.trigEn |-> !s_reg.widthMode) else $error("width w/o trig");
  AST_PERIOD_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.trigEn && $stable(s_reg.trigEn) |-> $stable(s_reg.periodUs))
    else $error("period changed in trigger mode");
  AST_EXPO_RANGE: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.expoUs >= 12'h004 && s_reg.expoUs <= 12'hbb8)
    else $error("exposure out of range");
  AST_TIMED_FALL: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.trigEn && !s_reg.widthMode && !s_reg.hot && $fell(s_reg.syncLvl)
    |-> exposing && lineBegin) else $error("timed start missed");
  AST_NO_INT_LINE: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.trigEn && $past(s_reg.trigEn) && !$changed(s_reg.syncLvl)
    |-> !lineBegin) else $error("internal line in trig mode");
  AST_ACK_ONE: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  // further guards; each watches flops and inputs of this block only
  // handshake checks: a taken request is answered on the next edge,
  // and an idle bus never sees an ack, so a master that waits for
  // ack cannot hang on a legal request
  AST_ACK_AFTER_REQ: assert property (@(posedge sys_clk)
    disable iff (!resetn) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  AST_NO_ACK_IDLE: assert property (@(posedge sys_clk)
    disable iff (!resetn) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // a free-run line begin always opens an exposure on the same edge
  AST_LINE_EXPO: assert property (@(posedge sys_clk)
    disable iff (!resetn) lineBegin && !$past(s_reg.trigEn) |-> exposing)
    else $error("free-run line without exposure");
  // one-cycle pulses never stretch
  AST_LINE_PULSE: assert property (@(posedge sys_clk)
    disable iff (!resetn) lineBegin |=> !lineBegin)
    else $error("line begin held");
  AST_READ_PULSE: assert property (@(posedge sys_clk)
    disable iff (!resetn) readoutStart |=> !readoutStart)
    else $error("readout start held");
  // sticky status: the event bit is set on the edge the pulse appears
  AST_STATUS_LINE: assert property (@(posedge sys_clk)
    disable iff (!resetn) lineBegin |-> s_reg.status[lsetc_pkg::ST_LINE_BIT])
    else $error("line event not recorded");
  // over-temperature stays latched until a reset command is taken
  AST_HOT_LATCH: assert property (@(posedge sys_clk)
    disable iff (!resetn) errorLed && !(wb_cyc_i && wb_stb_i && !wb_ack_o
    && wb_we_i && wb_sel_i[0] && wb_adr_i == lsetc_pkg::CTRL_OFS
    && wb_dat_i[lsetc_pkg::CTRL_RESET_BIT]) |=> errorLed)
    else $error("over-temperature cleared without command");
  // divider and period stay inside their legal ranges
  AST_DIV_RANGE: assert property (@(posedge sys_clk)
    disable iff (!resetn) s_reg.usDiv <= 8'(lsetc_pkg::TICKS_PER_US - 1))
    else $error("microsecond divider overran");
  AST_PERIOD_RANGE: assert property (@(posedge sys_clk)
    disable iff (!resetn) s_reg.periodUs >= lsetc_pkg::PERIOD_US_MIN
    && s_reg.periodUs <= lsetc_pkg::PERIOD_US_MAX)
    else $error("line period out of range");
endmodule
`default_nettype wire

// ### lsetc_fg_model.sv
// frame grabber model driving the external line sync line
`timescale 1ns/1ns
`default_nettype none
module lsetc_fg_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [15:0] highLen,
  output logic lineSync,
  output logic busy
);
  int cnt = 0; // cycles left in the current phase
  initial lineSync = 1'b0; // line idles low between pulses
  initial busy = 1'b0;
  // one high pulse of highLen cycles, then a low gap of 2 us
  always @(posedge sys_clk) begin
    if (go && !busy) begin
      lineSync <= 1'b1;
      busy <= 1'b1;
      cnt <= highLen;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (lineSync) begin
      lineSync <= 1'b0; // low gap keeps the camera's minimum low time
      cnt <= 500;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the line trigger and exposure block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int US = lsetc_pkg::TICKS_PER_US; // clocks per microsecond
  logic sysClk = 1'b0; // 250 MHz
  logic resetn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datW = 32'h0;
  logic [31:0] datR;
  logic [31:0] q;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack, lineSync, exposing, lineBegin, readoutStart, errorLed, irq;
  logic [7:0] tempC = 8'h1e; // cool start
  logic fgGo = 1'b0;
  logic fgBusy;
  logic [15:0] fgLen = 16'h0;
  int nErrors = 0, nTests = 0, nCyc = 0, nL = 0, nE = 0, nR = 0, bL, bE, bR;
  always #2 sysClk = ~sysClk;
  // event counters, updated late so a snapshot at an edge is exact
  always @(posedge sysClk) begin
    nL <= nL + int'(lineBegin === 1'b1);
    nE <= nE + int'(exposing === 1'b1);
    nR <= nR + int'(readoutStart === 1'b1);
    nCyc <= nCyc + 1;
    if (nCyc == 100000) begin
      nErrors++;
      wrap_up();
    end
  end
  lsetc_top u_dut (.sys_clk(sysClk), .resetn(resetn), .wb_adr_i(adr),
    .wb_dat_i(datW), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(datR), .wb_ack_o(ack),
    .external_line_sync(lineSync), .tempC(tempC), .exposing(exposing),
    .lineBegin(lineBegin), .readoutStart(readoutStart),
    .errorLed(errorLed), .irq(irq));
  lsetc_fg_model u_fg (.sys_clk(sysClk), .go(fgGo), .highLen(fgLen),
    .lineSync(lineSync), .busy(fgBusy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    datW <= d;
    we <= w;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge sysClk);
    end while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sysClk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic snap();
    bL = nL;
    bE = nE;
    bR = nR;
  endtask
  // one sync pulse, then let the timed exposure run out
  task automatic pulse(input int w);
    int k;
    k = 0;
    fgLen <= 16'(w);
    fgGo <= 1'b1;
    @(posedge sysClk);
    fgGo <= 1'b0;
    do begin
      @(posedge sysClk);
      k++;
    end while (fgBusy === 1'b1 && k < 5000);
    repeat (1200) @(posedge sysClk);
  endtask
  task automatic t_reset();
    rd(lsetc_pkg::CTRL_OFS, 32'h0);
    rd(lsetc_pkg::PERIOD_OFS, 32'h64);
    rd(lsetc_pkg::EXPO_OFS, 32'h32);
    rd(8'h40, 32'h0); // unmapped place reads zero
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_free();
    int k;
    k = 0;
    wb(1'b1, lsetc_pkg::PERIOD_OFS, 32'h0);
    rd(lsetc_pkg::PERIOD_OFS, 32'h15);
    wb(1'b1, lsetc_pkg::EXPO_OFS, 32'h0);
    rd(lsetc_pkg::EXPO_OFS, 32'h4);
    do begin
      @(posedge sysClk);
      k++;
    end while (lineBegin !== 1'b1 && k < 30000);
    snap();
    repeat (3 * 21 * US - 1) @(posedge sysClk);
    chk(nL - bL, 3);
    chk({31'h0, nE - bE >= 3 * 4 * US - 3 && nE - bE <= 3 * 4 * US + 4}, 1);
    chk(nR - bR, 3);
  endtask
  task automatic t_timed();
    wb(1'b1, lsetc_pkg::CTRL_OFS, 32'h1);
    wb(1'b1, lsetc_pkg::PERIOD_OFS, 32'h32);
    rd(lsetc_pkg::PERIOD_OFS, 32'h15);
    snap();
    repeat (6000) @(posedge sysClk);
    chk(nL - bL, 0);
    snap();
    pulse(20);
    chk(nL - bL, 1);
    chk({31'h0, nE - bE >= 4 * US - 2 && nE - bE <= 4 * US + 2}, 1);
  endtask
  task automatic t_width();
    wb(1'b1, lsetc_pkg::CTRL_OFS, 32'h2);
    rd(lsetc_pkg::CTRL_OFS, 32'h0);
    wb(1'b1, lsetc_pkg::CTRL_OFS, 32'h3);
    snap();
    pulse(600);
    chk({31'h0, nE - bE >= 599 && nE - bE <= 601}, 1);
    chk(nR - bR, 1);
  endtask
  // sticky status, mask, level interrupt
  task automatic t_irq();
    wb(1'b0, lsetc_pkg::STATUS_OFS, 32'h0);
    chk(q & 32'h3, 32'h3);
    wb(1'b1, lsetc_pkg::MASK_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, lsetc_pkg::MASK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, lsetc_pkg::STATUS_OFS, 32'h7);
    rd(lsetc_pkg::STATUS_OFS, 32'h0);
  endtask
  task automatic t_hot();
    tempC <= 8'h4b;
    repeat (10) @(posedge sysClk);
    chk({31'h0, errorLed}, 32'h0);
    tempC <= 8'h4c;
    repeat (10) @(posedge sysClk);
    chk({31'h0, errorLed}, 32'h1);
    tempC <= 8'h1e;
    snap();
    pulse(600);
    chk(nE - bE, 0);
    chk({31'h0, errorLed}, 32'h1);
    wb(1'b1, lsetc_pkg::CTRL_OFS, 32'h7);
    repeat (5) @(posedge sysClk);
    chk({31'h0, errorLed}, 32'h0);
    rd(lsetc_pkg::TEMP_OFS, 32'h1e);
  endtask
  task automatic wrap_up();
    $display("errors %0d, checks %0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sysClk);
    resetn <= 1'b1;
    @(posedge sysClk);
    t_reset();
    t_free();
    t_timed();
    t_width();
    t_irq();
    t_hot();
    wrap_up();
  end
endmodule
`default_nettype wire
